// *** hw/sec_loader.sv ***
// Serial EEPROM configuration loader and software command unit
`timescale 1ns/10ps
`include "sec_regs.svh"
module sec_loader #(
   parameter int BUF_DEPTH   = 2,
   parameter int WRITE_POLLS = 255
) (
   input  wire logic                      clock_in,
   input  wire logic                      reset_in,
   input  wire logic                      config_load_enable_pin_in,
   input  wire logic                      serial_data_output_in,
   output logic                           serial_chip_select_n_out,
   output logic                           serial_clock_out,
   output logic                           serial_data_input_out,
   output logic                           pci_retry_out,
   input  wire logic                      ctrl_wr_in,
   input  wire logic [31:0]               ctrl_wdata_in,
   output logic [31:0]                    ctrl_rdata_out,
   output logic                           cfg_valid_out,
   output sec_pkg::sec_cfg_word_type      cfg_word_out,
   input  wire logic                      cfg_ready_in
);
   // Elaboration check: the buffer is fixed at two entries, the poll count fits eight bits
   if (BUF_DEPTH != 2 || WRITE_POLLS < 1 || WRITE_POLLS > 255)
   begin
      $error("sec_loader: unsupported parameter values");
   end

   localparam logic [7:0] HALF_CYC = 8'(`SEC_SCK_HALF_CYC);
   localparam logic [7:0] GAP_CYC  = 8'(`SEC_CS_HIGH_CYC);

   // Pin input synchroniser, three stages; second and third must agree
   logic [2:0] so_sync_q;
   logic       so_bit_q;
   logic [2:0] le_sync_q;
   logic       le_q;
   logic [2:0] settle_q;
   // The strap is only trusted once the synchroniser has filled with real pin values
   always_ff @(posedge clock_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         so_sync_q <= 3'h0;
         so_bit_q  <= 1'b0;
         le_sync_q <= 3'h0;
         le_q      <= 1'b0;
         settle_q  <= 3'h0;
      end
      else
      begin
         if (settle_q != 3'h7)
            settle_q <= settle_q + 3'h1;
         so_sync_q <= {so_sync_q[1:0], serial_data_output_in};
         le_sync_q <= {le_sync_q[1:0], config_load_enable_pin_in};
         if (so_sync_q[1] == so_sync_q[2])
            so_bit_q <= so_sync_q[2];
         if (le_sync_q[1] == le_sync_q[2])
            le_q <= le_sync_q[2];
      end
   end

   // Two-entry output buffer toward configuration space
   sec_pkg::sec_cfg_word_type buf_mem_q [2];
   sec_pkg::sec_cfg_word_type buf_mem_d [2];
   logic [1:0] buf_cnt_q, buf_cnt_d;
   logic       buf_rd_q, buf_rd_d;
   logic       buf_wr_q, buf_wr_d;
   logic       buf_push, buf_pop, buf_full;
   sec_pkg::sec_cfg_word_type push_word;
   assign buf_full = (buf_cnt_q == 2'h2);
   assign buf_pop  = cfg_valid_out && cfg_ready_in;

   always_comb
   begin
      buf_mem_d = buf_mem_q;
      buf_cnt_d = buf_cnt_q;
      buf_rd_d  = buf_rd_q;
      buf_wr_d  = buf_wr_q;
      if (buf_push)
      begin
         buf_mem_d[buf_wr_q] = push_word;
         buf_wr_d = ~buf_wr_q;
      end
      if (buf_pop)
         buf_rd_d = ~buf_rd_q;
      buf_cnt_d = 2'(buf_cnt_q + {1'b0, buf_push} - {1'b0, buf_pop});
   end

   always_ff @(posedge clock_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         buf_mem_q[0]  <= '0;
         buf_mem_q[1]  <= '0;
         buf_cnt_q     <= 2'h0;
         buf_rd_q      <= 1'b0;
         buf_wr_q      <= 1'b0;
         cfg_valid_out <= 1'b0;
         cfg_word_out  <= '0;
      end
      else
      begin
         buf_mem_q     <= buf_mem_d;
         buf_cnt_q     <= buf_cnt_d;
         buf_rd_q      <= buf_rd_d;
         buf_wr_q      <= buf_wr_d;
         cfg_valid_out <= (buf_cnt_d != 2'h0);
         cfg_word_out  <= buf_mem_d[buf_rd_d];
      end
   end

   // Transaction engine: one frame of one to three bytes at a time, mode zero, MSB first
   sec_pkg::sec_state_type st_q, st_d;
   sec_pkg::sec_ctrl_type  ctrl_q, ctrl_d;
   logic [7:0]  sh_q, sh_d;
   logic [2:0]  bit_q, bit_d;
   logic [1:0]  nbytes_q, nbytes_d;
   logic [1:0]  byte_q, byte_d;
   logic [7:0]  div_q, div_d;
   logic        sck_q, sck_d;
   logic        cs_n_q, cs_n_d;
   logic        loading_q, loading_d;
   logic        write_latch_enable_instruction_q, write_latch_enable_instruction_d;
   logic        boot_q, boot_d;
   logic [7:0]  ld_addr_q, ld_addr_d;
   logic [31:0] ld_word_q, ld_word_d;
   logic [1:0]  ld_cnt_q, ld_cnt_d;
   logic [7:0]  polls_q, polls_d;
   logic [7:0]  tx2_q, tx2_d;
   logic [7:0]  tx3_q, tx3_d;
   logic        sw_cmd_q, sw_cmd_d;
   logic        poll_q, poll_d;

   always_comb
   begin
      st_d      = st_q;
      ctrl_d    = ctrl_q;
      sh_d      = sh_q;
      bit_d     = bit_q;
      nbytes_d  = nbytes_q;
      byte_d    = byte_q;
      div_d     = div_q;
      sck_d     = sck_q;
      cs_n_d    = cs_n_q;
      loading_d = loading_q;
      write_latch_enable_instruction_d    = write_latch_enable_instruction_q;
      boot_d    = boot_q;
      ld_addr_d = ld_addr_q;
      ld_word_d = ld_word_q;
      ld_cnt_d  = ld_cnt_q;
      polls_d   = polls_q;
      tx2_d     = tx2_q;
      tx3_d     = tx3_q;
      sw_cmd_d  = sw_cmd_q;
      poll_d    = poll_q;
      buf_push  = 1'b0;
      push_word.addr = {ld_addr_q[7:2] - 6'h1, 2'h0};
      push_word.data = ld_word_q;
      // Software writes only while idle; start stays set until the engine clears it
      if (ctrl_wr_in && !loading_q && !ctrl_q.start)
         ctrl_d = sec_pkg::sec_ctrl_type'(ctrl_wdata_in);
      case (st_q)
         sec_pkg::SEC_ST_IDLE:
         begin
            // Decision waits until the strap synchroniser has settled
            if (boot_q)
            begin
               if (settle_q == 3'h7)
                  boot_d = 1'b0;
               if (le_q && settle_q == 3'h7)
               begin
                  loading_d = 1'b1;
                  sh_d      = `SEC_INS_READ;
                  tx2_d     = 8'h00;
                  nbytes_d  = 2'h2;
                  st_d      = sec_pkg::SEC_ST_SEL;
               end
            end
            else if (ctrl_q.start)
            begin
               sw_cmd_d = 1'b1;
               tx2_d    = ctrl_q.addr;
               tx3_d    = ctrl_q.data;
               if ((ctrl_q.cmd == sec_pkg::SEC_CMD_WRITE || ctrl_q.cmd == sec_pkg::SEC_CMD_WRSR) && !write_latch_enable_instruction_q)
               begin
                  write_latch_enable_instruction_d   = 1'b1;
                  sh_d     = `SEC_INS_WRITE_LATCH_ENABLE_INSTRUCTION;
                  nbytes_d = 2'h0;
               end
               else
               begin
                  write_latch_enable_instruction_d = 1'b0;
                  case (ctrl_q.cmd)
                     sec_pkg::SEC_CMD_RDSR:
                     begin
                        sh_d     = `SEC_INS_RDSR;
                        nbytes_d = 2'h1;
                     end
                     sec_pkg::SEC_CMD_WRSR:
                     begin
                        sh_d     = `SEC_INS_WRSR;
                        tx2_d    = ctrl_q.data;
                        nbytes_d = 2'h1;
                     end
                     sec_pkg::SEC_CMD_READ:
                     begin
                        sh_d     = `SEC_INS_READ;
                        nbytes_d = 2'h2;
                     end
                     sec_pkg::SEC_CMD_WRITE:
                     begin
                        sh_d     = `SEC_INS_WRITE;
                        nbytes_d = 2'h2;
                     end
                     default:
                     begin
                        sh_d     = `SEC_INS_WRITE_LATCH_ENABLE_INSTRUCTION;
                        nbytes_d = 2'h0;
                     end
                  endcase
               end
               st_d = sec_pkg::SEC_ST_SEL;
            end
         end
         sec_pkg::SEC_ST_SEL:
         begin
            cs_n_d = 1'b0;
            sck_d  = 1'b0;
            bit_d  = 3'h7;
            byte_d = 2'h0;
            div_d  = HALF_CYC;
            st_d   = sec_pkg::SEC_ST_SHIFT;
         end
         // MSB first, data changes on falling edge, sampled rising
         sec_pkg::SEC_ST_SHIFT:
         begin
            if (div_q > 8'h1)
               div_d = div_q - 8'h1;
            else
            begin
               div_d = HALF_CYC;
               sck_d = ~sck_q;
               // Shift only on the falling edge: the input has then been settled past the
               // synchroniser for half a period, and the output moves while the memory is idle
               if (sck_q)
                  sh_d = {sh_q[6:0], so_bit_q};
               if (!sck_q)
                  bit_d = bit_q;
               else if (bit_q != 3'h0)
                  bit_d = bit_q - 3'h1;
               else if (byte_q != nbytes_q)
               begin
                  byte_d = byte_q + 2'h1;
                  bit_d  = 3'h7;
                  sh_d   = (byte_q == 2'h0) ? tx2_q : tx3_q;
               end
               else
                  st_d = sec_pkg::SEC_ST_DESEL;
            end
         end
         // chip select rises after last data bit
         sec_pkg::SEC_ST_DESEL:
         begin
            cs_n_d = 1'b1;
            div_d  = GAP_CYC;
            st_d   = sec_pkg::SEC_ST_GAP;
         end
         sec_pkg::SEC_ST_GAP:
         begin
            if (div_q > 8'h1)
               div_d = div_q - 8'h1;
            else if (loading_q)
               st_d = sec_pkg::SEC_ST_LDCHK;
            else if (write_latch_enable_instruction_q)
               st_d = sec_pkg::SEC_ST_IDLE;
            else if (ctrl_q.cmd == sec_pkg::SEC_CMD_WRITE || ctrl_q.cmd == sec_pkg::SEC_CMD_WRSR)
               st_d = sec_pkg::SEC_ST_POLL;
            else
               st_d = sec_pkg::SEC_ST_DONE;
         end
         // poll busy flag before clearing start
         sec_pkg::SEC_ST_POLL:
         begin
            // First visit follows the write frame; later ones follow a status frame
            if (!poll_q)
            begin
               poll_d   = 1'b1;
               polls_d  = 8'(WRITE_POLLS);
               sh_d     = `SEC_INS_RDSR;
               nbytes_d = 2'h1;
               tx2_d    = 8'h00;
               st_d     = sec_pkg::SEC_ST_SEL;
            end
            // Bounded, so a memory stuck busy still releases the start bit
            else if (sh_q[0] && polls_q > 8'h1)
            begin
               polls_d = polls_q - 8'h1;
               sh_d    = `SEC_INS_RDSR;
               st_d    = sec_pkg::SEC_ST_SEL;
            end
            else
            begin
               poll_d = 1'b0;
               st_d   = sec_pkg::SEC_ST_DONE;
            end
         end
         sec_pkg::SEC_ST_DONE:
         begin
            if (ctrl_q.cmd == sec_pkg::SEC_CMD_RDSR || ctrl_q.cmd == sec_pkg::SEC_CMD_READ)
               ctrl_d.data = sh_q;
            ctrl_d.start = 1'b0;
            sw_cmd_d     = 1'b0;
            st_d         = sec_pkg::SEC_ST_IDLE;
         end
         sec_pkg::SEC_ST_LDCHK:
         begin
            if (ld_addr_q == 8'h00)
            begin
               if (sh_q != `SEC_MARKER)
               begin
                  loading_d = 1'b0;
                  st_d      = sec_pkg::SEC_ST_IDLE;
               end
               else
               begin
                  ld_addr_d = `SEC_FIRST_ADDR;
                  sh_d      = `SEC_INS_READ;
                  tx2_d     = `SEC_FIRST_ADDR;
                  st_d      = sec_pkg::SEC_ST_SEL;
               end
            end
            // pack four bytes, first byte lowest
            else if (ld_cnt_q != 2'h3 || !buf_full)
            begin
               ld_word_d = {sh_q, ld_word_q[31:8]};
               ld_cnt_d  = ld_cnt_q + 2'h1;
               ld_addr_d = ld_addr_q + 8'h1;
               if (ld_cnt_q == 2'h3)
               begin
                  buf_push       = 1'b1;
                  push_word.addr = {ld_addr_q[7:2], 2'h0} - 8'h4;
                  push_word.data = {sh_q, ld_word_q[31:8]};
               end
               if (ld_addr_q == 8'hFF)
               begin
                  loading_d = 1'b0;
                  st_d      = sec_pkg::SEC_ST_IDLE;
               end
               else
               begin
                  sh_d  = `SEC_INS_READ;
                  tx2_d = ld_addr_q + 8'h1;
                  st_d  = sec_pkg::SEC_ST_SEL;
               end
            end
         end
         default:
            st_d = sec_pkg::SEC_ST_IDLE;
      endcase
   end

   always_ff @(posedge clock_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         st_q <= sec_pkg::SEC_ST_IDLE; ctrl_q <= sec_pkg::sec_ctrl_type'(`SEC_CTRL_RESET);
         sh_q <= 8'h00; bit_q <= 3'h0; nbytes_q <= 2'h0; byte_q <= 2'h0;
         div_q <= 8'h00; sck_q <= 1'b0; cs_n_q <= 1'b1; loading_q <= 1'b0;
         write_latch_enable_instruction_q <= 1'b0; boot_q <= 1'b1; ld_addr_q <= 8'h00; ld_word_q <= 32'h0000_0000;
         ld_cnt_q <= 2'h0; polls_q <= 8'h00; tx2_q <= 8'h00; tx3_q <= 8'h00; sw_cmd_q <= 1'b0;
         poll_q <= 1'b0;
         serial_chip_select_n_out <= 1'b1; serial_clock_out <= 1'b0; serial_data_input_out <= 1'b0;
         pci_retry_out <= 1'b0; ctrl_rdata_out <= `SEC_CTRL_RESET;
      end
      else
      begin
         st_q <= st_d; ctrl_q <= ctrl_d; sh_q <= sh_d; bit_q <= bit_d; nbytes_q <= nbytes_d;
         byte_q <= byte_d; div_q <= div_d; sck_q <= sck_d; cs_n_q <= cs_n_d; loading_q <= loading_d;
         write_latch_enable_instruction_q <= write_latch_enable_instruction_d; boot_q <= boot_d; ld_addr_q <= ld_addr_d; ld_word_q <= ld_word_d;
         ld_cnt_q <= ld_cnt_d; polls_q <= polls_d; tx2_q <= tx2_d; tx3_q <= tx3_d; sw_cmd_q <= sw_cmd_d;
         poll_q <= poll_d;
         serial_chip_select_n_out <= cs_n_d;
         serial_clock_out         <= sck_d;
         serial_data_input_out    <= sh_d[7];
         // retry during load, including the reset probe
         pci_retry_out  <= loading_d || (boot_d && le_q);
         ctrl_rdata_out <= 32'(ctrl_d);
      end
   end

   // start clears only via done state
   start_clear_a: assert property (@(posedge clock_in) disable iff (reset_in)
      $fell(ctrl_q.start) |-> $past(st_q) == sec_pkg::SEC_ST_DONE)
      else $error("start bit cleared outside completion");
   retry_load_a: assert property (@(posedge clock_in) disable iff (reset_in)
      loading_q |-> pci_retry_out) else $error("no retry during load");
   marker_stop_a: assert property (@(posedge clock_in) disable iff (reset_in)
      (st_q == sec_pkg::SEC_ST_LDCHK && ld_addr_q == 8'h00 && sh_q != `SEC_MARKER) |=> !loading_q)
      else $error("loading kept after marker mismatch");
   cs_idle_a: assert property (@(posedge clock_in) disable iff (reset_in)
      serial_chip_select_n_out |-> !serial_clock_out) else $error("clock active while deselected");
   word_align_a: assert property (@(posedge clock_in) disable iff (reset_in)
      buf_push |-> push_word.addr[1:0] == 2'h0) else $error("unaligned configuration word");
   read_data_a: assert property (@(posedge clock_in) disable iff (reset_in)
      (st_q == sec_pkg::SEC_ST_DONE && ctrl_q.cmd == sec_pkg::SEC_CMD_READ) |=> ctrl_q.data == $past(sh_q))
      else $error("read byte not stored");
   // latch enable frame carries no extra bytes
   write_latch_enable_instruction_frame_a: assert property (@(posedge clock_in) disable iff (reset_in)
      (st_q == sec_pkg::SEC_ST_SHIFT && write_latch_enable_instruction_q) |-> byte_q == 2'h0) else $error("latch enable too long");
   no_load_a: assert property (@(posedge clock_in) disable iff (reset_in)
      (boot_q && !le_q) |=> !loading_q) else $error("loaded while disabled");
   load_cov_c:  cover property (@(posedge clock_in) buf_push);
   sw_read_c:   cover property (@(posedge clock_in) st_q == sec_pkg::SEC_ST_DONE && ctrl_q.cmd == sec_pkg::SEC_CMD_READ);
   sw_write_c:  cover property (@(posedge clock_in) st_q == sec_pkg::SEC_ST_POLL);
   buf_stall_c: cover property (@(posedge clock_in) st_q == sec_pkg::SEC_ST_LDCHK && ld_cnt_q == 2'h3 && buf_full);
   // a software command keeps start set
   sw_busy_a: assert property (@(posedge clock_in) disable iff (reset_in)
      sw_cmd_q |-> ctrl_q.start) else $error("start bit low during software command");
endmodule

// *** hw/sec_regs.svh ***
// Offsets, field positions, reset values and timing counts of the serial EEPROM loader
`ifndef SEC_REGS_SVH
`define SEC_REGS_SVH
`define SEC_CTRL_OFFSET    8'h40
`define SEC_CTRL_RESET     32'h0000_0000
`define SEC_CTRL_DATA_LSB  0
`define SEC_CTRL_ADDR_LSB  8
`define SEC_CTRL_CMD_LSB   16
`define SEC_CTRL_START_BIT 31
`define SEC_MARKER         8'hAA
`define SEC_FIRST_ADDR     8'h01
`define SEC_INS_WRITE_LATCH_ENABLE_INSTRUCTION       8'h06
`define SEC_INS_WRSR       8'h01
`define SEC_INS_READ       8'h03
`define SEC_INS_WRITE      8'h02
`define SEC_INS_RDSR       8'h05
`define SEC_SCK_HALF_NS    80
`define SEC_CLK_NS         20
`define SEC_SCK_HALF_CYC   (((`SEC_SCK_HALF_NS) + (`SEC_CLK_NS) - 1) / (`SEC_CLK_NS))
`define SEC_CS_HIGH_NS     100
`define SEC_CS_HIGH_CYC    (((`SEC_CS_HIGH_NS) + (`SEC_CLK_NS) - 1) / (`SEC_CLK_NS))
`endif

// *** hw/sec_pkg.sv ***
// Types shared by the serial EEPROM loader
package sec_pkg;
   typedef enum logic [2:0] {
      SEC_CMD_RDSR  = 3'h0,
      SEC_CMD_WRSR  = 3'h1,
      SEC_CMD_READ  = 3'h2,
      SEC_CMD_WRITE = 3'h3,
      SEC_CMD_WRITE_LATCH_ENABLE_INSTRUCTION  = 3'h4
   } sec_cmd_type;

   typedef enum logic [7:0] {
      SEC_ST_IDLE   = 8'h01,
      SEC_ST_SEL    = 8'h02,
      SEC_ST_SHIFT  = 8'h04,
      SEC_ST_DESEL  = 8'h08,
      SEC_ST_GAP    = 8'h10,
      SEC_ST_LDCHK  = 8'h20,
      SEC_ST_POLL   = 8'h40,
      SEC_ST_DONE   = 8'h80
   } sec_state_type;

   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] data;
   } sec_cfg_word_type;

   typedef struct packed {
      logic        start;
      logic [11:0] unused;
      sec_cmd_type cmd;
      logic [7:0]  addr;
      logic [7:0]  data;
   } sec_ctrl_type;
endpackage

// *** tb/sec_eeprom_model.sv ***
// Behavioural serial EEPROM with eight-bit byte addressing, clock mode 0
`timescale 1ns/10ps
`include "sec_regs.svh"
module sec_eeprom_model (
   input  wire logic cs_n_in,
   input  wire logic sck_in,
   input  wire logic si_in,
   input  wire logic absent_in,
   output logic      so_out
);
   logic [7:0] mem[256];
   logic [7:0] ins_q, dat_q, addr_q, out_q, first_addr;
   logic [7:0] sr_q = 8'h00;
   logic       wel_q = 1'h0;
   logic       busy_q = 1'h0;
   int         cnt_q = 0;
   int         frames = 0;
   int         busy_ns = 5000;
   initial so_out = 1'h0;

   // A falling select starts a new frame
   always @(negedge cs_n_in)
   begin
      cnt_q = 0;
      if (!absent_in)
         frames++;
   end

   // Sample on the rising clock edge
   // MSB first
   always @(posedge sck_in)
   begin
      if (!cs_n_in && !absent_in)
      begin
         dat_q = {dat_q[6:0], si_in};
         cnt_q++;
         if (cnt_q == 8)
            ins_q = dat_q;
         if (cnt_q == 8 && ins_q == `SEC_INS_RDSR)
            out_q = {sr_q[7:2], wel_q, busy_q};
         if (cnt_q == 16)
            addr_q = dat_q;
         if (cnt_q == 16 && frames == 1)
            first_addr = dat_q;
         // One address byte, then data out
         if (cnt_q == 16 && ins_q == `SEC_INS_READ)
            out_q = mem[addr_q];
      end
   end

   // Shift out on falling edge; a released line flips so stale data never looks valid
   always @(negedge sck_in or posedge cs_n_in)
   begin
      if (cs_n_in || absent_in)
         so_out = ~so_out;
      else
      begin
         so_out = out_q[7];
         out_q = {out_q[6:0], 1'h1};
      end
   end

   // Latch set only by a lone enable frame; writes commit on select rise at exact length
   // Enable then commit
   always @(posedge cs_n_in)
   begin
      if (!absent_in && !busy_q)
      begin
         if (cnt_q == 8 && ins_q == `SEC_INS_WRITE_LATCH_ENABLE_INSTRUCTION)
            wel_q = 1'h1;
         else if (wel_q && ((cnt_q == 24 && ins_q == `SEC_INS_WRITE) || (cnt_q == 16 && ins_q == `SEC_INS_WRSR)))
         begin
            if (ins_q == `SEC_INS_WRITE)
               mem[addr_q] = dat_q;
            else
               sr_q = dat_q;
            wel_q = 1'h0;
            busy_q = 1'h1;
            busy_q <= #(busy_ns) 1'h0;
         end
      end
   end
endmodule

// *** tb/sec_loader_tb_top.sv ***
// Self-checking bench for the serial EEPROM loader
`timescale 1ns/10ps
module sec_loader_tb_top;
   logic                      clk, rst, strap, so, csn, sck, sdi, retry, wr, valid, ready, absent;
   logic [31:0]               wdata, rdata;
   sec_pkg::sec_cfg_word_type word;
   logic [39:0]               got[$];
   int                        n_errors = 0;
   int                        tests_run = 0;
   int                        cyc = 0;

   sec_loader #(.BUF_DEPTH(2), .WRITE_POLLS(255)) DUT (
      .clock_in(clk), .reset_in(rst), .config_load_enable_pin_in(strap),
      .serial_data_output_in(so), .serial_chip_select_n_out(csn), .serial_clock_out(sck),
      .serial_data_input_out(sdi), .pci_retry_out(retry), .ctrl_wr_in(wr), .ctrl_wdata_in(wdata),
      .ctrl_rdata_out(rdata), .cfg_valid_out(valid), .cfg_word_out(word), .cfg_ready_in(ready));

   sec_eeprom_model MEM (.cs_n_in(csn), .sck_in(sck), .si_in(sdi), .absent_in(absent), .so_out(so));

   // System clock
   initial
   begin
      clk = 1'h0;
      forever #10 clk = ~clk;
   end

   // Sink stalls early on, then accepts two cycles of three, to fill the buffer
   always @(negedge clk)
   begin
      cyc++;
      ready <= (cyc > 3000) && (cyc % 3 != 0);
   end

   // Collect every accepted configuration word
   always @(posedge clk)
      if (valid === 1'h1 && ready === 1'h1)
         got.push_back(word);

   task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic conclude();
      if (n_errors == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Bounded wait: for model busy, or for loader idle with start bit clear
   task automatic hold(input bit for_busy, input int lim);
      int i;
      i = 0;
      while ((for_busy ? MEM.busy_q !== 1'h1 : (retry !== 1'h0 || rdata[31] !== 1'h0)) && i < lim)
      begin
         @(negedge clk);
         i++;
      end
      if (i >= lim)
      begin
         n_errors++;
         conclude();
      end
   endtask

   task automatic restart(input logic load, input logic [7:0] first);
      @(negedge clk);
      rst = 1'h1;
      strap = load;
      MEM.mem[0] = first;
      MEM.frames = 0;
      cyc = 0;
      got.delete();
      repeat (10) @(negedge clk);
      rst = 1'h0;
   endtask

   // Address and data travel in the same write that sets start
   // Fields and start together
   task automatic issue(input sec_pkg::sec_cmd_type c, input logic [7:0] a, input logic [7:0] d);
      sec_pkg::sec_ctrl_type r;
      r = '{start: 1'h1, unused: 12'h000, cmd: c, addr: a, data: d};
      @(negedge clk);
      wr = 1'h1;
      wdata = r;
      @(negedge clk);
      wr = 1'h0;
   endtask

   task automatic cmd(input sec_pkg::sec_cmd_type c, input logic [7:0] a, input logic [7:0] d);
      issue(c, a, d);
      hold(1'b0, 20000);
   endtask

   // Marker matches: all 63 full words of the image arrive in order through a stalling sink
   task automatic sc_load();
      for (int i = 1; i < 256; i++)
         MEM.mem[i] = 8'(i * 7 + 3);
      restart(1'h1, 8'hAA);
      repeat (8) @(negedge clk);
      check("retry", retry, 40'h1);
      hold(1'b0, 60000);
      check("first", MEM.first_addr, 40'h0);
      check("count", got.size(), 40'h3F);
      foreach (got[k])
         check("word", got[k], {8'(4 * k), MEM.mem[4*k+4], MEM.mem[4*k+3], MEM.mem[4*k+2], MEM.mem[4*k+1]});
   endtask

   // Wrong marker: one frame only, no words, access reopened
   task automatic sc_mismatch();
      restart(1'h1, 8'h55);
      repeat (8) @(negedge clk);
      hold(1'b0, 2000);
      check("frames", MEM.frames, 40'h1);
      check("first", MEM.first_addr, 40'h0);
      check("count", got.size(), 40'h0);
   endtask

   // Strap low, then every software command, a dropped write and a missing EEPROM
   task automatic sc_software();
      restart(1'h0, 8'hAA);
      repeat (200) @(negedge clk);
      check("retry", retry, 40'h0);
      check("frames", MEM.frames, 40'h0);
      issue(sec_pkg::SEC_CMD_WRITE, 8'h33, 8'hC5);
      hold(1'b1, 5000);
      check("start", rdata[31], 40'h1);
      hold(1'b0, 20000);
      check("busy", MEM.busy_q, 40'h0);
      issue(sec_pkg::SEC_CMD_READ, 8'h33, 8'h00);
      issue(sec_pkg::SEC_CMD_WRITE, 8'h33, 8'h00);
      hold(1'b0, 20000);
      check("rd", rdata[7:0], 40'hC5);
      cmd(sec_pkg::SEC_CMD_READ, 8'h33, 8'h00);
      check("rd2", rdata[7:0], 40'hC5);
      cmd(sec_pkg::SEC_CMD_WRSR, 8'h00, 8'h8C);
      cmd(sec_pkg::SEC_CMD_RDSR, 8'h00, 8'h00);
      check("sr", rdata[7:0], 40'h8C);
      cmd(sec_pkg::SEC_CMD_WRITE_LATCH_ENABLE_INSTRUCTION, 8'h00, 8'h00);
      cmd(sec_pkg::SEC_CMD_RDSR, 8'h00, 8'h00);
      check("wel", rdata[7:0], 40'h8E);
      absent = 1'h1;
      cmd(sec_pkg::SEC_CMD_READ, 8'h10, 8'h00);
      check("absent", rdata[31], 40'h0);
      absent = 1'h0;
   endtask

   // Main sequence
   initial
   begin
      {rst, strap, wr, ready, absent} = 5'h10;
      wdata = 32'h0000_0000;
      sc_load();
      sc_mismatch();
      sc_software();
      conclude();
   end
endmodule
